/* File: design/ppd_defines.vh */
// constants for the packed parameter decoder
//
// Functional notes
// - Parameter 1 bits 0, 1, 2 set amp, mod, fm envelope multi trigger.
// - Parameter 1 bits 3-6: phase 0 free, 1-15 give 0-336 deg by 24 deg.
// - Parameter 2 bits 0-2: unison 0 off, 1-7 stack two to eight voices.
// - Parameter 2 bits 3-4 pick mono, mono glide, poly, poly same-note.
// - Parameter 2 bit 5 picks filter slope, 0 = 12 dB, 1 = 24 dB/octave.
// - Parameter 3 bit pairs 0-1, 2-3, 4-5 pick oscillator 1-3 waveform.
// - Parameter 3 bit 6 picks glide curve, 0 exponential and 1 linear.
// - Parameter 4 bit pairs 0-1, 2-3, 4-5 give oscillator 1-3 octave.
// - Parameter 4 bit 6 set hard-syncs oscillator 2 to oscillator 1.
// - Parameter 5 bits 0 and 1 enable multi-trigger delay of lfo 1 and 2.
// - Parameter 5 bit pairs 2-3 and 4-5 pick lfo 1 and lfo 2 waveform.
// - Parameter 6 bits 0 and 3 pick the restart phase shift of lfo 1, 2.
// - Parameter 6 bits 1 and 4 enable key-synchronised lfo 1, 2 restart.
// - Parameter 6 bits 2 and 5 pick per-voice (0) or shared (1) phase.
// - Locked keysync restarts on lone note, post-change note, song start.
`ifndef PPD_DEFINES_VH
`define PPD_DEFINES_VH

// parameter numbers on the select input
`define PPD_SEL_ENV 3'h1
`define PPD_SEL_UNI 3'h2
`define PPD_SEL_OWAVE 3'h3
`define PPD_SEL_OCT 3'h4
`define PPD_SEL_LWAVE 3'h5
`define PPD_SEL_LSYNC 3'h6

// masks of assigned bits per parameter
`define PPD_MASK_ENV 7'h7f
`define PPD_MASK_UNI 7'h3f
`define PPD_MASK_OWAVE 7'h7f
`define PPD_MASK_OCT 7'h7f
`define PPD_MASK_LWAVE 7'h3f
`define PPD_MASK_LSYNC 7'h3f

// reset values of the stored parameters
`define PPD_RST_ENV 7'h00
`define PPD_RST_UNI 7'h00
`define PPD_RST_OWAVE 7'h00
`define PPD_RST_OCT 7'h00
`define PPD_RST_LWAVE 7'h00
`define PPD_RST_LSYNC 7'h00
`define PPD_RST_WFREE 1'b1
`define PPD_RST_VOICES 4'h1

// field positions
`define PPD_WPH_LSB 3
`define PPD_WPH_MSB 6
`define PPD_UNI_MSB 2
`define PPD_VMODE_LSB 3
`define PPD_FILT_BIT 5
`define PPD_GLIDE_BIT 6
`define PPD_SYNC_BIT 6
`define PPD_LFO2_OFS 3
`define PPD_PAIR0_LSB 0
`define PPD_PAIR1_LSB 2
`define PPD_PAIR2_LSB 4

// keysync phase step in degrees
`define PPD_PHASE_STEP 9'h018

`endif

/* File: design/ppd_packed_param_decoder.v */
// packed parameter decoder: unpacks six 7-bit packed voice parameters
`include "ppd_defines.vh"
`default_nettype none

module ppd_packed_param_decoder
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // packed value write
  input wire i_param_valid,
  input wire [2:0] i_param_sel,
  input wire [6:0] i_param_value,
  // readback of stored values
  input wire [2:0] i_read_sel,
  output reg [6:0] o_read_data,
  // note and transport events
  input wire i_note_on,
  input wire i_notes_held,
  input wire i_prog_change,
  input wire i_song_start,
  // envelope and wave keysync fields
  output reg o_amp_env_multi,
  output reg o_mod_env_multi,
  output reg o_fm_env_multi,
  output reg o_wave_sync_free,
  output reg [8:0] o_wave_sync_phase_deg,
  // unison, voicing and filter
  output reg o_unison_on,
  output reg [3:0] o_unison_voices,
  output reg [1:0] o_voice_mode,
  output reg o_filter_24db,
  // oscillator waveforms and glide
  output reg [1:0] o_osc1_wave,
  output reg [1:0] o_osc2_wave,
  output reg [1:0] o_osc3_wave,
  output reg o_glide_linear,
  // oscillator octaves and hard sync
  output reg [1:0] o_osc1_octave,
  output reg [1:0] o_osc2_octave,
  output reg [1:0] o_osc3_octave,
  output reg o_osc2_hard_sync,
  // lfo delay and waveform
  output reg o_lfo1_delay_multi,
  output reg o_lfo2_delay_multi,
  output reg [1:0] o_lfo1_wave,
  output reg [1:0] o_lfo2_wave,
  // lfo keysync, lock and phase
  output reg o_lfo1_phase_shift,
  output reg o_lfo1_keysync,
  output reg o_lfo1_lock,
  output reg o_lfo2_phase_shift,
  output reg o_lfo2_keysync,
  output reg o_lfo2_lock,
  // lfo restart strobes
  output reg o_lfo1_restart,
  output reg o_lfo2_restart
);

  // ==========================================================
  // write decode
  // ==========================================================

  // one strobe per parameter; unknown numbers write nothing
  wire wr_env;
  wire wr_uni;
  wire wr_owave;
  wire wr_oct;
  wire wr_lwave;
  wire wr_lsync;

  assign wr_env = i_param_valid & (i_param_sel == `PPD_SEL_ENV);
  assign wr_uni = i_param_valid & (i_param_sel == `PPD_SEL_UNI);
  assign wr_owave = i_param_valid & (i_param_sel == `PPD_SEL_OWAVE);
  assign wr_oct = i_param_valid & (i_param_sel == `PPD_SEL_OCT);
  assign wr_lwave = i_param_valid & (i_param_sel == `PPD_SEL_LWAVE);
  assign wr_lsync = i_param_valid & (i_param_sel == `PPD_SEL_LSYNC);

  // stored packed values, unassigned bits kept at zero
  reg [6:0] envelope_trigger_and_wave_phase;
  reg [6:0] unison_voicing_filter_slope;
  reg [6:0] oscillator_waveforms_glide_curve;
  reg [6:0] oscillator_octaves_hard_sync;
  reg [6:0] lfo_waveform_delay_select;
  reg [6:0] lfo_sync_lock_phase;

  // ==========================================================
  // derived values of the wave keysync and unison fields
  // ==========================================================

  // phase nibble and unison count of the incoming value
  wire [3:0] in_phase;
  wire [2:0] in_unison;
  wire [8:0] next_phase_deg;
  wire [3:0] next_unison_voices;

  assign in_phase = i_param_value[`PPD_WPH_MSB:`PPD_WPH_LSB];
  assign in_unison = i_param_value[`PPD_UNI_MSB:0];
  // code n gives (n-1) steps; code 0 means free-running
  assign next_phase_deg = (in_phase == 4'h0) ? 9'h000 :
    ({5'h00, in_phase} - 9'h001) * `PPD_PHASE_STEP;
  // count n stacks n+1 voices, zero leaves one voice
  assign next_unison_voices = (in_unison == 3'h0) ? 4'h1 :
    ({1'b0, in_unison} + 4'h1);

  // ==========================================================
  // two-bit field slices of the incoming value
  // ==========================================================

  // parameters 3 and 4 keep their two-bit fields at the same
  // three places, parameter 5 at the upper two, so one set of
  // slices serves all of them and a moved field only needs its
  // position changed in one spot
  wire [1:0] in_pair0;
  wire [1:0] in_pair1;
  wire [1:0] in_pair2;

  assign in_pair0 = i_param_value[`PPD_PAIR0_LSB+1:`PPD_PAIR0_LSB];
  assign in_pair1 = i_param_value[`PPD_PAIR1_LSB+1:`PPD_PAIR1_LSB];
  assign in_pair2 = i_param_value[`PPD_PAIR2_LSB+1:`PPD_PAIR2_LSB];

  // ==========================================================
  // stored parameter registers
  // ==========================================================

  // each write touches only its own parameter
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      envelope_trigger_and_wave_phase <= `PPD_RST_ENV;
      unison_voicing_filter_slope <= `PPD_RST_UNI;
      oscillator_waveforms_glide_curve <= `PPD_RST_OWAVE;
      oscillator_octaves_hard_sync <= `PPD_RST_OCT;
      lfo_waveform_delay_select <= `PPD_RST_LWAVE;
      lfo_sync_lock_phase <= `PPD_RST_LSYNC;
    end
    else
    begin
      if (wr_env)
      begin
        envelope_trigger_and_wave_phase <=
          i_param_value & `PPD_MASK_ENV;
      end
      if (wr_uni)
      begin
        unison_voicing_filter_slope <=
          i_param_value & `PPD_MASK_UNI;
      end
      if (wr_owave)
      begin
        oscillator_waveforms_glide_curve <=
          i_param_value & `PPD_MASK_OWAVE;
      end
      if (wr_oct)
      begin
        oscillator_octaves_hard_sync <=
          i_param_value & `PPD_MASK_OCT;
      end
      if (wr_lwave)
      begin
        lfo_waveform_delay_select <=
          i_param_value & `PPD_MASK_LWAVE;
      end
      if (wr_lsync)
      begin
        lfo_sync_lock_phase <= i_param_value & `PPD_MASK_LSYNC;
      end
    end
  end

  // ==========================================================
  // decoded field outputs
  // ==========================================================

  // fields load in the same edge as the packed value, so the voice
  // engine never sees a half-updated parameter
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_amp_env_multi <= 1'b0;
      o_mod_env_multi <= 1'b0;
      o_fm_env_multi <= 1'b0;
      o_wave_sync_free <= `PPD_RST_WFREE;
      o_wave_sync_phase_deg <= 9'h000;
      o_unison_on <= 1'b0;
      o_unison_voices <= `PPD_RST_VOICES;
      o_voice_mode <= 2'h0;
      o_filter_24db <= 1'b0;
      o_osc1_wave <= 2'h0;
      o_osc2_wave <= 2'h0;
      o_osc3_wave <= 2'h0;
      o_glide_linear <= 1'b0;
      o_osc1_octave <= 2'h0;
      o_osc2_octave <= 2'h0;
      o_osc3_octave <= 2'h0;
      o_osc2_hard_sync <= 1'b0;
      o_lfo1_delay_multi <= 1'b0;
      o_lfo2_delay_multi <= 1'b0;
      o_lfo1_wave <= 2'h0;
      o_lfo2_wave <= 2'h0;
      o_lfo1_phase_shift <= 1'b0;
      o_lfo1_keysync <= 1'b0;
      o_lfo1_lock <= 1'b0;
      o_lfo2_phase_shift <= 1'b0;
      o_lfo2_keysync <= 1'b0;
      o_lfo2_lock <= 1'b0;
    end
    else
    begin
      // envelope triggers and wave keysync phase
      if (wr_env)
      begin
        o_amp_env_multi <= i_param_value[0];
        o_mod_env_multi <= i_param_value[1];
        o_fm_env_multi <= i_param_value[2];
        o_wave_sync_free <= (in_phase == 4'h0);
        o_wave_sync_phase_deg <= next_phase_deg;
      end
      // unison, voice allocation and filter slope; bit 6 dropped
      if (wr_uni)
      begin
        o_unison_on <= (in_unison != 3'h0);
        o_unison_voices <= next_unison_voices;
        o_voice_mode <= i_param_value[`PPD_VMODE_LSB+1:`PPD_VMODE_LSB];
        o_filter_24db <= i_param_value[`PPD_FILT_BIT];
      end
      // oscillator waveforms and glide curve
      if (wr_owave)
      begin
        o_osc1_wave <= in_pair0;
        o_osc2_wave <= in_pair1;
        o_osc3_wave <= in_pair2;
        o_glide_linear <= i_param_value[`PPD_GLIDE_BIT];
      end
      // octave codes pass as stored: 0 means one octave down
      if (wr_oct)
      begin
        o_osc1_octave <= in_pair0;
        o_osc2_octave <= in_pair1;
        o_osc3_octave <= in_pair2;
        o_osc2_hard_sync <= i_param_value[`PPD_SYNC_BIT];
      end
      // lfo delay multi and waveforms; bit 6 dropped
      if (wr_lwave)
      begin
        o_lfo1_delay_multi <= i_param_value[0];
        o_lfo2_delay_multi <= i_param_value[1];
        o_lfo1_wave <= in_pair1;
        o_lfo2_wave <= in_pair2;
      end
      // lfo keysync, lock and phase, second lfo three bits up
      if (wr_lsync)
      begin
        o_lfo1_phase_shift <= i_param_value[0];
        o_lfo1_keysync <= i_param_value[1];
        o_lfo1_lock <= i_param_value[2];
        o_lfo2_phase_shift <= i_param_value[`PPD_LFO2_OFS];
        o_lfo2_keysync <= i_param_value[`PPD_LFO2_OFS+1];
        o_lfo2_lock <= i_param_value[`PPD_LFO2_OFS+2];
      end
    end
  end

  // ==========================================================
  // lfo restart generation
  // ==========================================================

  // remembers a program change until the next note arrives
  reg first_after_pc;

  // a change in the same cycle as a note wins, so that note does
  // not consume it and the following note is the first one
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      first_after_pc <= 1'b0;
    end
    else if (i_prog_change)
    begin
      first_after_pc <= 1'b1;
    end
    else if (i_note_on)
    begin
      first_after_pc <= 1'b0;
    end
  end

  // global restart: lone note, first note after change, song start
  wire global_sync;

  assign global_sync = i_song_start |
    (i_note_on & (~i_notes_held | first_after_pc));

  // a note and a song start in one cycle give a single strobe;
  // locked lfo follows the global events, free lfo every note;
  // uses the settings already stored, not a write in flight
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_lfo1_restart <= 1'b0;
      o_lfo2_restart <= 1'b0;
    end
    else
    begin
      o_lfo1_restart <= o_lfo1_keysync &
        (o_lfo1_lock ? global_sync : i_note_on);
      o_lfo2_restart <= o_lfo2_keysync &
        (o_lfo2_lock ? global_sync : i_note_on);
    end
  end

  // ==========================================================
  // readback
  // ==========================================================

  // registered mux; unknown numbers read as zero
  // the select is sampled every edge, so data trails it by a cycle
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_read_data <= 7'h00;
    end
    else
    begin
      case (i_read_sel)
        `PPD_SEL_ENV: o_read_data <= envelope_trigger_and_wave_phase;
        `PPD_SEL_UNI: o_read_data <= unison_voicing_filter_slope;
        `PPD_SEL_OWAVE: o_read_data <= oscillator_waveforms_glide_curve;
        `PPD_SEL_OCT: o_read_data <= oscillator_octaves_hard_sync;
        `PPD_SEL_LWAVE: o_read_data <= lfo_waveform_delay_select;
        `PPD_SEL_LSYNC: o_read_data <= lfo_sync_lock_phase;
        default: o_read_data <= 7'h00;
      endcase
    end
  end

endmodule // ppd_packed_param_decoder

`default_nettype wire

/* File: sim/ppd_monitor.sv */
// assertion checker bound to the packed parameter decoder
`default_nettype none
module ppd_monitor
(
  // clock, reset and inputs
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_param_valid,
  input wire logic [2:0] i_param_sel,
  input wire logic [6:0] i_param_value,
  input wire logic i_note_on,
  input wire logic i_song_start,
  // decoded outputs
  input wire logic o_amp_env_multi,
  input wire logic o_mod_env_multi,
  input wire logic o_fm_env_multi,
  input wire logic o_wave_sync_free,
  input wire logic [8:0] o_wave_sync_phase_deg,
  input wire logic o_unison_on,
  input wire logic [3:0] o_unison_voices,
  input wire logic [1:0] o_voice_mode,
  input wire logic o_filter_24db,
  input wire logic o_lfo1_keysync,
  input wire logic o_lfo1_lock,
  input wire logic o_lfo1_restart
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==============================
  // field and strobe relations
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // one-hot write strobe per parameter number
  wire logic [7:0] wr = i_param_valid ? 8'h01 << i_param_sel : 8'h00;
  chk_env_trigger: assert property (wr[1] |=>
    {o_fm_env_multi, o_mod_env_multi, o_amp_env_multi}
    == $past(i_param_value[2:0])) else $error("env trigger bits wrong");
  chk_wave_phase: assert property (wr[1] |=>
    o_wave_sync_free == ($past(i_param_value[6:3]) == 4'h0) &&
    (o_wave_sync_free || o_wave_sync_phase_deg ==
    9'h018 * ($past(i_param_value[6:3]) - 4'h1)))
    else $error("keysync phase wrong");
  chk_unison_count: assert property (wr[2] |=>
    o_unison_on == ($past(i_param_value[2:0]) != 3'h0) &&
    o_unison_voices == $past(i_param_value[2:0]) + 4'h1)
    else $error("unison count wrong");
  chk_voicing_slope: assert property (wr[2] |=>
    {o_filter_24db, o_voice_mode} == $past(i_param_value[5:3]))
    else $error("voicing or slope wrong");
  chk_lfo_lock: assert property (wr[6] |=>
    o_lfo1_lock == $past(i_param_value[2]) &&
    o_lfo1_keysync == $past(i_param_value[1]))
    else $error("lfo lock or keysync wrong");
  // a strobe must have keysync and an event one cycle before
  chk_restart_cause: assert property (o_lfo1_restart |->
    $past(o_lfo1_keysync) && $past(i_note_on || i_song_start))
    else $error("restart without cause");
  chk_free_note: assert property (i_note_on && o_lfo1_keysync &&
    !o_lfo1_lock |=> o_lfo1_restart) else $error("unlocked note missed");
  // writes elsewhere leave the parameter 1 phase and the amp and fm triggers alone
  chk_other_hold: assert property (i_param_valid &&
    i_param_sel != 3'h1 |=> $stable({o_wave_sync_phase_deg,
    o_amp_env_multi, o_fm_env_multi})) else $error("fields disturbed");
endmodule // ppd_monitor

bind ppd_packed_param_decoder ppd_monitor i_mon (.*);
`default_nettype wire

/* File: sim/ppd_midi_src.sv */
// controller source model: packed values and note events
`default_nettype none
module ppd_midi_src
(
  // clock
  input wire logic i_clk,
  // packed value write
  output logic o_valid,
  output logic [2:0] o_sel,
  output logic [6:0] o_value,
  // note and transport events
  output logic o_note,
  output logic o_held,
  output logic o_prog,
  output logic o_song
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==============================
  // drivers
  initial
  begin
    {o_valid, o_sel, o_value, o_note, o_held, o_prog, o_song} = '0;
  end
  // one value per call; calls back to back keep the strobe up
  task send(input logic [2:0] s, input logic [6:0] v);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_sel = s;
    o_value = v;
  endtask
  // stale select and value are scrambled so nothing leans on them
  task stop;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_sel = ~o_sel;
    o_value = ~o_value;
  endtask
  // one-cycle pulse: 0 note, 1 song start, 2 program change
  task pulse(input int k, input logic h);
    @(posedge i_clk);
    #1;
    o_held = h;
    o_note = (k == 0);
    o_song = (k == 1);
    o_prog = (k == 2);
    @(posedge i_clk);
    #1;
    {o_note, o_song, o_prog} = 3'h0;
  endtask
endmodule // ppd_midi_src
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench of the packed parameter decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] i_read_sel = 3'h0;
  logic [2:0] i_param_sel;
  logic [6:0] i_param_value, o_read_data;
  logic [8:0] o_wave_sync_phase_deg;
  logic [3:0] o_unison_voices;
  logic [1:0] o_voice_mode, o_osc1_wave, o_osc2_wave, o_osc3_wave;
  logic [1:0] o_osc1_octave, o_osc2_octave, o_osc3_octave;
  logic [1:0] o_lfo1_wave, o_lfo2_wave;
  logic i_param_valid, i_note_on, i_notes_held, i_prog_change;
  logic i_song_start, o_amp_env_multi, o_mod_env_multi, o_fm_env_multi;
  logic o_wave_sync_free, o_unison_on, o_filter_24db, o_glide_linear;
  logic o_osc2_hard_sync, o_lfo1_delay_multi, o_lfo2_delay_multi;
  logic o_lfo1_phase_shift, o_lfo1_keysync, o_lfo1_lock, o_lfo1_restart;
  logic o_lfo2_phase_shift, o_lfo2_keysync, o_lfo2_lock, o_lfo2_restart;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // ==============================
  // harness
  ppd_packed_param_decoder i_dut (.*);
  ppd_midi_src i_src (.i_clk(i_ref_clk), .o_valid(i_param_valid),
    .o_sel(i_param_sel), .o_value(i_param_value), .o_note(i_note_on),
    .o_held(i_notes_held), .o_prog(i_prog_change), .o_song(i_song_start));
  always #12.5 i_ref_clk = ~i_ref_clk;
  // hang guard, well above the under two thousand cycles needed
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  task wrap_up;
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // readback one cycle after the select is set
  task rd(input logic [2:0] s, input logic [6:0] e);
    i_read_sel = s;
    @(posedge i_ref_clk);
    #1;
    chk(o_read_data, e);
  endtask
  // reset for 20 cycles, then defaults on ten of the outputs
  task t_reset;
    @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b0;
    i_read_sel = 3'h2;
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    chk({o_wave_sync_free, o_unison_voices, o_read_data}, 12'h880);
    chk(|{o_wave_sync_phase_deg, o_amp_env_multi, o_voice_mode,
      o_osc1_octave, o_lfo2_wave, o_lfo2_lock, o_lfo1_restart}, 1'h0);
  endtask
  // every code of every field, six writes back to back
  task t_sweep;
    logic [6:0] p [1:6];
    logic [3:0] ph;
    for (int v = 0; v < 128; v++)
    begin
      for (int s = 1; s <= 6; s++)
      begin
        p[s] = 7'(v + 37 * s);
        i_src.send(3'(s), p[s]);
      end
      i_src.stop;
      ph = p[1][6:3];
      chk({o_fm_env_multi, o_mod_env_multi, o_amp_env_multi},
        p[1][2:0]);
      chk({o_wave_sync_free, o_wave_sync_phase_deg},
        {ph == 4'h0, ph == 4'h0 ? 9'h000 : 9'(9'h018 * (ph - 4'h1))});
      chk({o_unison_on, o_unison_voices},
        {p[2][2:0] != 0, 4'(p[2][2:0]) + 4'h1});
      chk(o_voice_mode, p[2][4:3]);
      chk(o_filter_24db, p[2][5]);
      chk({o_osc3_wave, o_osc2_wave, o_osc1_wave}, p[3][5:0]);
      chk(o_glide_linear, p[3][6]);
      chk({o_osc3_octave, o_osc2_octave, o_osc1_octave}, p[4][5:0]);
      chk(o_osc2_hard_sync, p[4][6]);
      chk({o_lfo2_delay_multi, o_lfo1_delay_multi}, p[5][1:0]);
      chk({o_lfo2_wave, o_lfo1_wave}, p[5][5:2]);
      chk({o_lfo2_phase_shift, o_lfo1_phase_shift},
        {p[6][3], p[6][0]});
      chk({o_lfo2_keysync, o_lfo1_keysync}, {p[6][4], p[6][1]});
      chk({o_lfo2_lock, o_lfo1_lock}, {p[6][5], p[6][2]});
      for (int s = 1; s <= 6; s++)
        rd(3'(s), s inside {2, 5, 6} ? p[s] & 7'h3f : p[s]);
    end
  endtask
  // numbers 0 and 7 and an unassigned bit change nothing
  task t_refuse;
    i_src.send(3'h1, 7'h7f);
    i_src.send(3'h0, 7'h00);
    i_src.send(3'h7, 7'h00);
    i_src.send(3'h2, 7'h40);
    i_src.stop;
    chk({o_fm_env_multi, o_wave_sync_phase_deg}, 10'h350);
    chk({o_unison_on, o_voice_mode, o_filter_24db}, 4'h0);
    rd(3'h1, 7'h7f);
    rd(3'h0, 7'h00);
    rd(3'h7, 7'h00);
    rd(3'h2, 7'h00);
  endtask
  task ev(input int k, input logic h, input logic [1:0] e);
    i_src.pulse(k, h);
    chk({o_lfo2_restart, o_lfo1_restart}, e);
  endtask
  // free and locked restart, program change flag, keysync off
  task t_restart;
    i_src.send(3'h6, 7'h02);
    i_src.stop;
    ev(0, 1, 2'b01);
    ev(1, 0, 2'b00);
    i_src.send(3'h6, 7'h36);
    i_src.stop;
    ev(0, 0, 2'b11);
    ev(0, 1, 2'b00);
    ev(1, 1, 2'b11);
    ev(2, 1, 2'b00);
    ev(0, 1, 2'b11);
    ev(0, 1, 2'b00);
    i_src.send(3'h6, 7'h24);
    i_src.stop;
    ev(1, 0, 2'b00);
  endtask
  initial
  begin
    t_reset;
    t_sweep;
    t_refuse;
    t_restart;
    t_reset;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
